// ==== fbc_pkg.sv ====
/*
 * Shared constants, carriers and helpers for the fieldbus test-constant
 * and input-image register block.
 * Assumes a word-addressed register port of 16-bit data driven by the
 * network-side protocol engine, and I/O slot data sampled on mclk.
 */
package fbc_pkg;

    // Register word addresses
    localparam logic [15:0] ADDR_PROBE = 16'h2002;
    localparam logic [15:0] ADDR_MASK_HIGH = 16'h2003;
    localparam logic [15:0] ADDR_MASK_LOW = 16'h2004;
    localparam logic [15:0] ADDR_MAX_POS = 16'h2005;
    localparam logic [15:0] ADDR_MAX_NEG = 16'h2006;
    localparam logic [15:0] ADDR_HALF_POS = 16'h2007;
    localparam logic [15:0] ADDR_HALF_NEG = 16'h2008;
    localparam logic [15:0] ADDR_RETAIN_FIRST = 16'h3000;
    localparam logic [15:0] ADDR_RETAIN_LAST = 16'h5FFF;
    localparam logic [15:0] ADDR_IMAGE_BASE = 16'h0000;

    // Constant register values
    localparam logic [15:0] VAL_PROBE = 16'h1234;
    localparam logic [15:0] VAL_MASK_HIGH = 16'hAAAA;
    localparam logic [15:0] VAL_MASK_LOW = 16'h5555;
    localparam logic [15:0] VAL_MAX_POS = 16'h7FFF;
    localparam logic [15:0] VAL_MAX_NEG = 16'h8000;
    localparam logic [15:0] VAL_HALF_POS = 16'h3FFF;
    localparam logic [15:0] VAL_HALF_NEG = 16'hC000;
    localparam logic [15:0] VAL_IMAGE_RESET = 16'h0000;

    // Sizes of the retain store and the input image
    localparam int RETAIN_WORDS = 12288;
    localparam int NUM_SLOTS = 4;
    localparam int ANALOG_WORDS = 4;
    localparam int DIG_WORDS = 2;
    localparam int IMAGE_WORDS = ANALOG_WORDS + DIG_WORDS;

    // Bit positions inside a digital module field
    localparam int POS_STATE_CH1 = 0;
    localparam int POS_STATE_CH2 = 1;
    localparam int POS_FAULT_SINGLE = 1;
    localparam int POS_FAULT_CH1 = 2;
    localparam int POS_FAULT_CH2 = 3;

    // Kinds of digital input module that a slot may hold
    typedef enum logic [2:0] {
        FBC_MOD_NONE,
        FBC_MOD_DI1_DIAG,
        FBC_MOD_DI2,
        FBC_MOD_DI2_DIAG,
        FBC_MOD_DI4,
        FBC_MOD_DI8
    } fbc_mod_kind_t;

    typedef struct packed {
        fbc_mod_kind_t kind;
        logic [7:0] state;
        logic [7:0] fault;
    } fbc_slot_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
    } fbc_req_t;

    typedef struct packed {
        logic valid;
        logic err;
        logic [15:0] data;
    } fbc_rsp_t;

    // Byte swap for the big-endian word format
    function automatic logic [15:0] fbc_swap16(input logic [15:0] w);
        fbc_swap16 = {w[7:0], w[15:8]};
    endfunction

endpackage

// ==== fbc_di_packer.sv ====
/*
 * Packs the digital input slots into one contiguous bit string.
 * Assumes slot 0 is nearest the controller; each slot's field lands
 * directly after the fields of all slots before it.
 */
module fbc_di_packer (
    input wire fbc_pkg::fbc_slot_t [fbc_pkg::NUM_SLOTS-1:0] slots,
    output logic [31:0] di_bits
);

    // Field of one module, unused upper bits forced to zero
    function automatic logic [7:0] slot_field(input fbc_pkg::fbc_slot_t s);
        logic [7:0] f;
        f = 8'h00;
        case (s.kind)
            fbc_pkg::FBC_MOD_DI1_DIAG: begin
                f[fbc_pkg::POS_STATE_CH1] = s.state[0]; // R13 R10
                f[fbc_pkg::POS_FAULT_SINGLE] = s.fault[0]; // R13 R11
            end
            fbc_pkg::FBC_MOD_DI2: begin
                f[fbc_pkg::POS_STATE_CH1] = s.state[0]; // R14
                f[fbc_pkg::POS_STATE_CH2] = s.state[1]; // R14
            end
            fbc_pkg::FBC_MOD_DI2_DIAG: begin
                f[fbc_pkg::POS_STATE_CH1] = s.state[0]; // R15
                f[fbc_pkg::POS_STATE_CH2] = s.state[1]; // R15
                f[fbc_pkg::POS_FAULT_CH1] = s.fault[0]; // R15 R11
                f[fbc_pkg::POS_FAULT_CH2] = s.fault[1]; // R15 R11
            end
            fbc_pkg::FBC_MOD_DI4: f[3:0] = s.state[3:0]; // R10 R16
            fbc_pkg::FBC_MOD_DI8: f = s.state; // R10
            default: f = 8'h00;
        endcase
        slot_field = f;
    endfunction

    // Number of image bits a module occupies
    function automatic logic [5:0] slot_width(input fbc_pkg::fbc_mod_kind_t k);
        case (k)
            fbc_pkg::FBC_MOD_DI1_DIAG: slot_width = 6'd2;
            fbc_pkg::FBC_MOD_DI2: slot_width = 6'd2;
            fbc_pkg::FBC_MOD_DI2_DIAG: slot_width = 6'd4;
            fbc_pkg::FBC_MOD_DI4: slot_width = 6'd4;
            fbc_pkg::FBC_MOD_DI8: slot_width = 6'd8;
            default: slot_width = 6'd0;
        endcase
    endfunction

    // Offset grows with every preceding module
    always_comb begin
        logic [5:0] off;
        off = 6'd0;
        di_bits = 32'h0000_0000;
        for (int i = 0; i < fbc_pkg::NUM_SLOTS; i++) begin
            di_bits = di_bits | ({24'h00_0000, slot_field(slots[i])} << off); // R8
            off = off + slot_width(slots[i].kind); // R8
        end
    end

endmodule

// ==== fbc_regs.sv ====
/*
 * Register block: communication test constants, the flag/retain store
 * and the word-aligned input process image, on one word register port.
 * Assumes requests are single-cycle strobes synchronous to mclk and that
 * slot and analog inputs are already synchronous to mclk.
 */
// Summary of operation
// R1: The probe word reads 0x1234 in little-endian format and appears byte-swapped as 0x3412 in big-endian format.
// R2: Two read-only mask words sit at consecutive addresses so a master can test every bit.
// R3: The first mask reads 0xAAAA and the second its complement 0x5555.
// R4: Four read-only arithmetic constants give largest positive, largest negative, and the halves of each.
// R5: Every word from 0x3000 through 0x5FFF is readable and writable storage.
// R6: The input image is a sequence of 16-bit words with every item word aligned.
// R7: Items wider than a byte are stored least significant byte first.
// R8: A module's image position is the sum of the data of all modules before it.
// R9: The controller-side image has exactly the same layout as the fieldbus image.
// R10: Each digital input channel gives exactly one signal-state bit.
// R11: Modules with diagnostics add one fault bit per channel.
// R12: Digital bits follow all analog data, packed into bytes.
// R13: A one-channel diagnostic module has state at bit 0 and fault at bit 1.
// R14: A two-channel module has channel 1 at bit 0 and channel 2 at bit 1.
// R15: A two-channel diagnostic module has states at bits 0 and 1 and faults at bits 2 and 3.
// R16: Unused upper bits of a module read zero and writes to constants are ignored.
module fbc_regs (
    input wire logic mclk,
    input wire logic rst,
    input wire fbc_pkg::fbc_req_t req,
    output fbc_pkg::fbc_rsp_t rsp,
    input wire logic word_format_big,
    input wire logic [2:0] analog_word_count,
    input wire logic [fbc_pkg::ANALOG_WORDS-1:0][15:0] analog_data,
    input wire fbc_pkg::fbc_slot_t [fbc_pkg::NUM_SLOTS-1:0] slots,
    output logic [fbc_pkg::IMAGE_WORDS-1:0][15:0] programmable_controller_image
);

    logic [15:0] retain_mem [fbc_pkg::RETAIN_WORDS];
    logic [31:0] di_bits;
    logic [fbc_pkg::IMAGE_WORDS-1:0][15:0] image;
    logic [fbc_pkg::IMAGE_WORDS-1:0][15:0] next_image;
    logic [3:0] image_len;
    logic [13:0] retain_idx;
    logic in_retain;
    logic in_image;
    logic is_const;
    logic [15:0] read_plain;
    logic read_hit;
    logic rsp_valid;
    logic rsp_err;
    logic [15:0] rsp_data;
    logic fmt_q;
    logic [15:0] rsp_plain;

    fbc_di_packer u_packer (
        .slots(slots),
        .di_bits(di_bits)
    );

    // Analog words first, then digital bytes, low byte first
    always_comb begin
        logic [3:0] j;
        j = 4'd0;
        for (int i = 0; i < fbc_pkg::IMAGE_WORDS; i++) begin
            j = 4'(i) - {1'b0, analog_word_count};
            // Counts above the analog depth never index past the analog array
            if ((4'(i) < {1'b0, analog_word_count}) && (i < fbc_pkg::ANALOG_WORDS)) begin
                next_image[i] = analog_data[i]; // R12 R6
            end else if (j < 4'(fbc_pkg::DIG_WORDS)) begin
                next_image[i] = di_bits[j[0]*16 +: 16]; // R7 R12
            end else begin
                next_image[i] = fbc_pkg::VAL_IMAGE_RESET;
            end
        end
    end

    // Image refreshed every cycle; one copy feeds both consumers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            image <= '0;
        end else begin
            image <= next_image; // R6
        end
    end

    assign programmable_controller_image = image; // R9
    assign image_len = {1'b0, analog_word_count} + 4'(fbc_pkg::DIG_WORDS);

    // Address decode
    assign in_retain = (req.addr >= fbc_pkg::ADDR_RETAIN_FIRST)
        && (req.addr <= fbc_pkg::ADDR_RETAIN_LAST); // R5
    assign retain_idx = 14'(req.addr - fbc_pkg::ADDR_RETAIN_FIRST);
    assign in_image = (req.addr - fbc_pkg::ADDR_IMAGE_BASE) < {12'h000, image_len};
    assign is_const = (req.addr >= fbc_pkg::ADDR_PROBE)
        && (req.addr <= fbc_pkg::ADDR_HALF_NEG);

    // Read mux in little-endian terms; swap is applied afterwards
    always_comb begin
        read_plain = 16'h0000;
        read_hit = 1'b1;
        case (req.addr)
            fbc_pkg::ADDR_PROBE: read_plain = fbc_pkg::VAL_PROBE; // R1
            fbc_pkg::ADDR_MASK_HIGH: read_plain = fbc_pkg::VAL_MASK_HIGH; // R2 R3
            fbc_pkg::ADDR_MASK_LOW: read_plain = fbc_pkg::VAL_MASK_LOW; // R2 R3
            fbc_pkg::ADDR_MAX_POS: read_plain = fbc_pkg::VAL_MAX_POS; // R4
            fbc_pkg::ADDR_MAX_NEG: read_plain = fbc_pkg::VAL_MAX_NEG; // R4
            fbc_pkg::ADDR_HALF_POS: read_plain = fbc_pkg::VAL_HALF_POS; // R4
            fbc_pkg::ADDR_HALF_NEG: read_plain = fbc_pkg::VAL_HALF_NEG; // R4
            default: begin
                if (in_retain) begin
                    read_plain = retain_mem[retain_idx]; // R5
                end else if (in_image) begin
                    read_plain = image[req.addr[2:0]]; // R9
                end else begin
                    read_hit = 1'b0;
                end
            end
        endcase
    end

    // Retain store; no reset since contents must survive a soft reset
    always_ff @(posedge mclk) begin
        if (req.wr && in_retain) begin
            retain_mem[retain_idx] <= word_format_big
                ? fbc_pkg::fbc_swap16(req.wdata) : req.wdata; // R5 R1
        end
    end

    // Answer one cycle after each strobe; write wins if both are set
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_err <= 1'b0;
            rsp_data <= 16'h0000;
        end else begin
            rsp_valid <= req.rd || req.wr;
            if (req.wr) begin
                rsp_err <= !(in_retain || is_const); // R16
                rsp_data <= 16'h0000;
            end else if (req.rd) begin
                rsp_err <= !read_hit;
                rsp_data <= word_format_big
                    ? fbc_pkg::fbc_swap16(read_plain) : read_plain; // R1
            end else begin
                rsp_err <= 1'b0;
            end
        end
    end

    assign rsp.valid = rsp_valid;
    assign rsp.err = rsp_err;
    assign rsp.data = rsp_data;

    // Helper for checks: answer seen back in little-endian terms
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            fmt_q <= 1'b0;
        end else begin
            fmt_q <= word_format_big;
        end
    end

    assign rsp_plain = fmt_q ? fbc_pkg::fbc_swap16(rsp_data) : rsp_data;

    AST_PROBE_LITTLE: assert property (@(posedge mclk) disable iff (rst) // R1
        (req.rd && !req.wr && req.addr == fbc_pkg::ADDR_PROBE && !word_format_big)
        |=> rsp_valid && !rsp_err && rsp_data == 16'h1234)
        else $error("probe word wrong in little-endian format");

    AST_PROBE_BIG: assert property (@(posedge mclk) disable iff (rst) // R1
        (req.rd && !req.wr && req.addr == fbc_pkg::ADDR_PROBE && word_format_big)
        |=> rsp_valid && rsp_data == 16'h3412)
        else $error("probe word not swapped in big-endian format");

    AST_MASK_PAIR: assert property (@(posedge mclk) disable iff (rst) // R3
        (req.rd && !req.wr && req.addr == fbc_pkg::ADDR_MASK_HIGH)
        ##1 (req.rd && !req.wr && req.addr == fbc_pkg::ADDR_MASK_LOW)
        |=> (rsp_plain == 16'h5555) && ($past(rsp_plain) == 16'hAAAA))
        else $error("mask pair does not cover every bit in both states");

    AST_ARITH_LIMITS: assert property (@(posedge mclk) disable iff (rst) // R4
        (req.rd && !req.wr && req.addr == fbc_pkg::ADDR_MAX_NEG)
        |=> rsp_plain == 16'h8000 && !rsp_err)
        else $error("largest negative constant wrong");

    AST_ARITH_HALF: assert property (@(posedge mclk) disable iff (rst) // R4
        (req.rd && !req.wr && req.addr == fbc_pkg::ADDR_HALF_POS)
        |=> rsp_plain == 16'h3FFF)
        else $error("half positive constant wrong");

    AST_RETAIN_BACK: assert property (@(posedge mclk) disable iff (rst) // R5
        (req.wr && in_retain)
        ##1 (req.rd && !req.wr && req.addr == $past(req.addr) && $stable(word_format_big))
        |=> rsp_valid && !rsp_err && rsp_plain ==
            (fmt_q ? fbc_pkg::fbc_swap16($past(req.wdata, 2)) : $past(req.wdata, 2)))
        else $error("retain word did not read back as written");

    AST_CONST_WRITE: assert property (@(posedge mclk) disable iff (rst) // R16
        (req.wr && req.addr == fbc_pkg::ADDR_PROBE)
        ##1 (req.rd && !req.wr && req.addr == fbc_pkg::ADDR_PROBE && !word_format_big)
        |=> !rsp_err && rsp_data == 16'h1234 && $past(rsp_valid && !rsp_err))
        else $error("write to a constant was not ignored");

    AST_UNMAPPED: assert property (@(posedge mclk) disable iff (rst)
        (req.rd && !req.wr && req.addr == 16'h2FFF)
        |=> rsp_valid && rsp_err)
        else $error("unmapped read not flagged");

    AST_DIAG_SINGLE: assert property (@(posedge mclk) disable iff (rst) // R13
        (analog_word_count == 3'd0 && slots[0].kind == fbc_pkg::FBC_MOD_DI1_DIAG
            && slots[1].kind == fbc_pkg::FBC_MOD_NONE
            && slots[2].kind == fbc_pkg::FBC_MOD_NONE
            && slots[3].kind == fbc_pkg::FBC_MOD_NONE)
        |=> image[0][0] == $past(slots[0].state[0])
            && image[0][1] == $past(slots[0].fault[0]) && image[0][15:2] == 14'h0000)
        else $error("single-channel diagnostic layout wrong");

    AST_TWO_CHANNEL: assert property (@(posedge mclk) disable iff (rst) // R14
        (analog_word_count == 3'd0 && slots[0].kind == fbc_pkg::FBC_MOD_DI2)
        |=> image[0][1:0] == $past(slots[0].state[1:0]))
        else $error("two-channel layout wrong");

    AST_TWO_DIAG: assert property (@(posedge mclk) disable iff (rst) // R15
        (analog_word_count == 3'd0 && slots[0].kind == fbc_pkg::FBC_MOD_DI2_DIAG)
        |=> image[0][3:0] == {$past(slots[0].fault[1:0]), $past(slots[0].state[1:0])})
        else $error("two-channel diagnostic layout wrong");

    AST_OFFSET_CHAIN: assert property (@(posedge mclk) disable iff (rst) // R8
        (analog_word_count == 3'd0 && slots[0].kind == fbc_pkg::FBC_MOD_DI2_DIAG
            && slots[1].kind == fbc_pkg::FBC_MOD_DI8)
        |=> image[0][11:4] == $past(slots[1].state))
        else $error("second module not placed after the first");

    AST_ANALOG_FIRST: assert property (@(posedge mclk) disable iff (rst) // R12
        (analog_word_count == 3'd1 && slots[0].kind == fbc_pkg::FBC_MOD_DI8)
        |=> image[0] == $past(analog_data[0]) && image[1][7:0] == $past(slots[0].state))
        else $error("digital bits not after analog data");

    AST_CTRL_IMAGE: assert property (@(posedge mclk) disable iff (rst) // R9
        (req.rd && !req.wr && req.addr == 16'h0000 && !word_format_big)
        |=> rsp_data == $past(programmable_controller_image[0]))
        else $error("fieldbus and controller images differ");

endmodule

// ==== fbc_master_model.sv ====
/*
 * Fieldbus master model: single word reads and writes on the register port.
 * Assumes the answer comes one cycle after the taking edge and that every
 * call starts just after a rising edge of mclk.
 */
module fbc_master_model (
    input wire logic mclk,
    output fbc_pkg::fbc_req_t req,
    input wire fbc_pkg::fbc_rsp_t rsp
);
    timeunit 1ns;
    timeprecision 1ps;

    // Quiet bus until the first request
    initial begin
        req = '0;
    end

    // One transfer; lat counts edges from taking edge to answer
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic e, output int lat);
        lat = 0;
        req <= '{rd: ~w, wr: w, addr: a, wdata: d};
        @(posedge mclk);
        // Released lines show the inverse, so a stale copy cannot pass
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        do begin
            @(posedge mclk);
            lat++;
        end while (rsp.valid !== 1'b1 && lat < 4);
        q = rsp.data;
        e = rsp.err;
    endtask

    // Back-to-back pair: any first access, then a read in the very next cycle
    task automatic pair(input logic w1, input logic [15:0] a1, input logic [15:0] d1,
                        input logic [15:0] a2, output logic [15:0] q1,
                        output logic [15:0] q2);
        req <= '{rd: ~w1, wr: w1, addr: a1, wdata: d1};
        @(posedge mclk);
        req <= '{rd: 1'b1, wr: 1'b0, addr: a2, wdata: ~d1};
        @(posedge mclk);
        q1 = rsp.data;
        req <= '{rd: 1'b0, wr: 1'b0, addr: ~a2, wdata: d1};
        @(posedge mclk);
        q2 = rsp.data;
    endtask
endmodule

// ==== tb_top.sv ====
/*
 * Self-checking bench for the register block: constants, retain store,
 * input image layout and reset.
 * Assumes the master model answers on the register port and slot kinds
 * pack 2, 2, 4 and 8 bits for the kinds used here.
 */
`define FBC_CHK(g, x) begin n_checks++; if ((g) !== (x)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, x); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic fmt;
        logic wr;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] exp;
        logic err;
    } fbc_row_t;

    logic mclk;
    logic rst;
    fbc_pkg::fbc_req_t req;
    fbc_pkg::fbc_rsp_t rsp;
    logic word_format_big;
    logic [2:0] analog_word_count;
    logic [fbc_pkg::ANALOG_WORDS-1:0][15:0] analog_data;
    fbc_pkg::fbc_slot_t [fbc_pkg::NUM_SLOTS-1:0] slots;
    logic [fbc_pkg::IMAGE_WORDS-1:0][15:0] image;
    logic [15:0] q;
    logic [15:0] q2;
    logic e;
    int lat;
    int fails;
    int n_checks;
    fbc_row_t rows [20];

    fbc_regs dut (
        .mclk(mclk),
        .rst(rst),
        .req(req),
        .rsp(rsp),
        .word_format_big(word_format_big),
        .analog_word_count(analog_word_count),
        .analog_data(analog_data),
        .slots(slots),
        .programmable_controller_image(image)
    );

    fbc_master_model m (
        .mclk(mclk),
        .req(req),
        .rsp(rsp)
    );

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic summarize();
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Read one word and expect a clean answer
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] x);
        m.xfer(1'b0, a, 16'h0000, q, e, lat);
        `FBC_CHK({e, q}, {1'b0, x})
    endtask

    // Outputs quiet while reset is applied
    task automatic reset_chk();
        `FBC_CHK({rsp.valid, rsp.err, rsp.data}, 18'h0_0000)
        `FBC_CHK(image, '0)
    endtask

    // Hang guard, far beyond the hundred or so cycles of the run
    initial begin
        #200000;
        fails++;
        summarize();
    end

    initial begin
        fails = 0;
        n_checks = 0;
        rst = 1'b1;
        word_format_big = 1'b0;
        analog_word_count = 3'h0;
        analog_data = '0;
        slots = '0;
        rows = '{
            '{1'b0, 1'b0, 16'h2002, 16'h0000, 16'h1234, 1'b0},
            '{1'b1, 1'b0, 16'h2002, 16'h0000, 16'h3412, 1'b0},
            '{1'b0, 1'b0, 16'h2003, 16'h0000, 16'hAAAA, 1'b0},
            '{1'b0, 1'b0, 16'h2004, 16'h0000, 16'h5555, 1'b0},
            '{1'b0, 1'b0, 16'h2005, 16'h0000, 16'h7FFF, 1'b0},
            '{1'b0, 1'b0, 16'h2006, 16'h0000, 16'h8000, 1'b0},
            '{1'b0, 1'b0, 16'h2007, 16'h0000, 16'h3FFF, 1'b0},
            '{1'b0, 1'b0, 16'h2008, 16'h0000, 16'hC000, 1'b0},
            '{1'b0, 1'b1, 16'h2005, 16'h0000, 16'h0000, 1'b0},
            '{1'b0, 1'b0, 16'h2005, 16'h0000, 16'h7FFF, 1'b0},
            '{1'b0, 1'b1, 16'h3000, 16'hBEEF, 16'h0000, 1'b0},
            '{1'b0, 1'b1, 16'h5FFF, 16'h1357, 16'h0000, 1'b0},
            '{1'b0, 1'b0, 16'h3000, 16'h0000, 16'hBEEF, 1'b0},
            '{1'b0, 1'b0, 16'h5FFF, 16'h0000, 16'h1357, 1'b0},
            '{1'b1, 1'b1, 16'h4000, 16'h1122, 16'h0000, 1'b0},
            '{1'b0, 1'b0, 16'h4000, 16'h0000, 16'h2211, 1'b0},
            '{1'b1, 1'b0, 16'h4000, 16'h0000, 16'h1122, 1'b0},
            '{1'b0, 1'b0, 16'h2000, 16'h0000, 16'h0000, 1'b1},
            '{1'b0, 1'b1, 16'h6000, 16'hABCD, 16'h0000, 1'b1},
            '{1'b0, 1'b0, 16'h2FFF, 16'h0000, 16'h0000, 1'b1}
        };
        repeat (8) @(posedge mclk);
        reset_chk();
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        // Table of constant, retain and refused accesses
        foreach (rows[i]) begin
            word_format_big <= rows[i].fmt;
            m.xfer(rows[i].wr, rows[i].addr, rows[i].wdata, q, e, lat);
            `FBC_CHK({e, q}, {rows[i].err, rows[i].exp})
            `FBC_CHK(lat, 1)
        end
        // Back-to-back accesses: mask pair, retain write-then-read, constant write
        m.pair(1'b0, 16'h2003, 16'h0000, 16'h2004, q, q2);
        `FBC_CHK({q, q2}, 32'hAAAA_5555)
        m.pair(1'b1, 16'h3001, 16'h5A5A, 16'h3001, q, q2);
        `FBC_CHK({q, q2}, 32'h0000_5A5A)
        m.pair(1'b1, 16'h2002, 16'hFFFF, 16'h2002, q, q2);
        `FBC_CHK({q, q2}, 32'h0000_1234)
        // Two analog words, then 2+2+4+8 digital bits; high state bits unused
        word_format_big <= 1'b0;
        analog_word_count <= 3'h2;
        analog_data <= {16'h4444, 16'h3333, 16'h2222, 16'h1111};
        slots[0] <= '{kind: fbc_pkg::FBC_MOD_DI1_DIAG, state: 8'h01, fault: 8'hFE};
        slots[1] <= '{kind: fbc_pkg::FBC_MOD_DI2, state: 8'hFE, fault: 8'hFF};
        slots[2] <= '{kind: fbc_pkg::FBC_MOD_DI2_DIAG, state: 8'hF1, fault: 8'hF2};
        slots[3] <= '{kind: fbc_pkg::FBC_MOD_DI8, state: 8'hA5, fault: 8'h00};
        repeat (2) @(posedge mclk);
        rd_chk(16'h0000, 16'h1111);
        rd_chk(16'h0001, 16'h2222);
        rd_chk(16'h0002, 16'hA599);
        rd_chk(16'h0003, 16'h0000);
        `FBC_CHK(image[2], 16'hA599)
        `FBC_CHK(image[0], 16'h1111)
        // No analog data: digital word moves to word 0; fault lands at bit 1
        analog_word_count <= 3'h0;
        slots[0] <= '{kind: fbc_pkg::FBC_MOD_DI1_DIAG, state: 8'h00, fault: 8'h01};
        repeat (2) @(posedge mclk);
        rd_chk(16'h0000, 16'hA59A);
        word_format_big <= 1'b1;
        rd_chk(16'h0000, 16'h9AA5);
        `FBC_CHK(image[0], 16'hA59A)
        // Lone diagnostic module, other slots empty
        slots[0] <= '{kind: fbc_pkg::FBC_MOD_DI1_DIAG, state: 8'h01, fault: 8'h00};
        slots[1] <= '0;
        slots[2] <= '0;
        slots[3] <= '0;
        repeat (2) @(posedge mclk);
        `FBC_CHK(image[0], 16'h0001)
        // Two-channel then four-channel module
        slots[0] <= '{kind: fbc_pkg::FBC_MOD_DI2, state: 8'hFD, fault: 8'hFF};
        slots[1] <= '{kind: fbc_pkg::FBC_MOD_DI4, state: 8'hFA, fault: 8'hFF};
        repeat (2) @(posedge mclk);
        `FBC_CHK(image[0], 16'h0029)
        // Diagnostic pair followed by an eight-channel module
        slots[0] <= '{kind: fbc_pkg::FBC_MOD_DI2_DIAG, state: 8'h02, fault: 8'h01};
        slots[1] <= '{kind: fbc_pkg::FBC_MOD_DI8, state: 8'h3C, fault: 8'h00};
        repeat (2) @(posedge mclk);
        `FBC_CHK(image[0], 16'h03C6)
        // One analog word ahead of the digital byte
        analog_word_count <= 3'h1;
        slots[0] <= '{kind: fbc_pkg::FBC_MOD_DI8, state: 8'h5A, fault: 8'h00};
        slots[1] <= '0;
        repeat (2) @(posedge mclk);
        `FBC_CHK({image[1], image[0]}, 32'h005A_1111)
        // Reset in mid-run; retain contents survive it
        word_format_big <= 1'b0;
        rst <= 1'b1;
        @(negedge mclk);
        reset_chk();
        @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd_chk(16'h3000, 16'hBEEF);
        summarize();
    end
endmodule
